/* File: verilog/spn_nc_core.sv */
/*
  Positioning NC core: ramped pulse generation for stepping, jogging,
  teaching and origin return, with polarity mask, option word and errors.
  Assumes synchronous inputs on mclk, command strobes one cycle wide,
  and the host keeping configuration stable while a move runs.
*/
// Contract
// R1: Stepping ramp 10-2000 ms to 500 kpps
// R2: Step with unset ramp raises error 52
// R3: Separate jog and origin ramps, same behaviour
// R4: Jog direction bit selects jog travel
// R5: Origin direction bit selects search direction
// R6: Pulse direction bit sets coordinate sign
// R7: Teach key press moves configured pulse count
// R8: S-curve 0 or 10 linear, else S
// R9: Polarity mask inverts inputs, bit5 emergency
// R10: Mask bits 0 and 1 invert limits
// R11: Option word latched only at power reset
// R12: Option bit0 picks decel or finished output
// R13: Option bit selects travel to origin offset
// R14: Host keeps reserved option bit cleared
// R15: Option bit3 allows command emergency recovery
// R16: Option bit selects relative-only, no overflow
// R17: Option bit selects servo-off reset or hold
// R18: Option bit selects limit torque handling
// R19: Options at bits 1,4,5,6; bit2 reserved
// R20: Constant ramp rate equal both directions
`include "spn_map.svh"

module spn_nc_core (
  input wire logic mclk,
  input wire logic resetn,
  input wire spn_pkg::spn_cfg_s cfg,
  input wire spn_pkg::spn_cmd_s cmd,
  output logic pulseOut,
  output logic dirOut,
  output logic sharedOut,
  output spn_pkg::spn_status_s status
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [10:0] selRamp(input spn_pkg::spn_mode_e md,
                                          input spn_pkg::spn_cfg_s c);
    logic [10:0] r;
    case (md)
      spn_pkg::MD_STEP: r = c.stepRampMs;
      spn_pkg::MD_ORIGIN: r = c.originRampMs;
      default: r = c.jogRampMs;
    endcase
    // Out-of-range times are clamped rather than trusted
    if (r < `SPN_RAMP_MS_MIN) begin
      r = `SPN_RAMP_MS_MIN;
    end else if (r > `SPN_RAMP_MS_MAX) begin
      r = `SPN_RAMP_MS_MAX;
    end
    return r;
  endfunction : selRamp

  function automatic logic [31:0] magOf(input logic signed [31:0] v);
    return v[31] ? 32'(-v) : 32'(v);
  endfunction : magOf

  ////////////////////////////////////////////////////////////////////////
  // State

  spn_pkg::spn_state_s s_q;
  spn_pkg::spn_state_s s_d;

  logic [12:0] inEff;
  logic cwLim;
  logic ccwLim;
  logic emergency_stop_input;
  logic [10:0] rampMs;
  logic [18:0] velTarget;
  logic [18:0] sBand;
  logic sShaped;
  logic [2:0] inc;
  logic [11:0] accSum;
  logic [27:0] phaseSum;
  logic blocked;
  logic emit;
  logic signed [31:0] posNext;
  logic signed [31:0] delta;
  logic startOk;
  logic rampSet;

  always_comb begin
    s_d = s_q;
    s_d.pulse = 1'b0;
    inEff = cmd.rawInputs ^ cfg.inputMask; // [R9] [R10]
    cwLim = inEff[`SPN_IN_CW_BIT]; // [R10]
    ccwLim = inEff[`SPN_IN_CCW_BIT]; // [R10]
    emergency_stop_input = inEff[`SPN_IN_EMG_BIT]; // [R9]
    rampMs = selRamp(s_q.mode, cfg); // [R1] [R3]
    velTarget = (cmd.velPps > `SPN_REF_PPS) ? `SPN_REF_PPS : cmd.velPps;
    if (velTarget < `SPN_VEL_MIN) begin
      velTarget = `SPN_VEL_MIN;
    end
    sBand = 19'(cfg.sCurve * `SPN_S_BAND_PPS);
    // Zero and full scale both mean a straight ramp
    sShaped = (cfg.sCurve != 4'h0) && (cfg.sCurve < `SPN_S_LINEAR_HI); // [R8]
    inc = `SPN_RAMP_INC; // [R20]
    if (sShaped && ((s_q.vel < sBand) || ((velTarget - s_q.vel) < sBand))) begin
      inc = `SPN_RAMP_INC_S; // [R8]
    end
    accSum = {1'b0, s_q.rampAcc} + 12'(inc);
    phaseSum = {1'b0, s_q.phase} + 28'(s_q.vel);
    blocked = s_q.dirPos ? cwLim : ccwLim; // [R18]
    emit = 1'b0;
    posNext = s_q.status.position;
    delta = 32'sh00000000;
    startOk = 1'b0;
    rampSet = 1'b0;

    // Option word is caught once after power reset only
    if (!s_q.optTaken) begin
      s_d.opt = cfg.optionWord; // [R11] [R19]
      s_d.optTaken = 1'b1;
    end

    s_d.status.torqueInhibitCw = cwLim & ~s_q.opt[`SPN_OPT_LIMTQ_BIT]; // [R18]
    s_d.status.torqueInhibitCcw = ccwLim & ~s_q.opt[`SPN_OPT_LIMTQ_BIT]; // [R18]

    ////////////////////////////////////////////////////////////////////
    // Error clearing, then setting, so a fresh event wins

    if (cmd.resetCmd && (!s_q.emgLatched || s_q.opt[`SPN_OPT_EMG_RST_BIT])) begin
      // Latched emergency needs the command-recovery option [R15]
      s_d.status.errActive = 1'b0;
      s_d.status.errCode = `SPN_ERR_NONE;
      s_d.emgLatched = 1'b0;
    end

    if (emergency_stop_input) begin
      s_d.emgLatched = 1'b1; // [R15]
      s_d.status.errActive = 1'b1;
      s_d.status.errCode = `SPN_ERR_EMG;
      s_d.st = spn_pkg::ST_IDLE;
      s_d.vel = 19'h00000;
      s_d.offsetPending = 1'b0;
    end else if (!cmd.servoOn) begin
      if (!s_q.opt[`SPN_OPT_SVOFF_BIT]) begin
        s_d.st = spn_pkg::ST_IDLE; // [R17]
        s_d.vel = 19'h00000;
        s_d.rampAcc = 11'h000;
        s_d.offsetPending = 1'b0;
      end
      // Hold mode: every motion field simply keeps its value [R17]
    end else if (s_q.optTaken) begin
      case (s_q.st)
        spn_pkg::ST_IDLE: begin
          s_d.rampAcc = 11'h000;
          s_d.phase = 27'h0000000;
          s_d.accelCnt = 32'h00000000;
          if (s_q.status.errActive) begin
            startOk = 1'b0;
          end else if (s_q.offsetPending) begin
            s_d.offsetPending = 1'b0;
            s_d.mode = spn_pkg::MD_ORIGIN; // [R13]
            s_d.bounded = 1'b1;
            s_d.dirPos = ~cfg.originOffset[31];
            s_d.remain = magOf(cfg.originOffset);
            rampSet = cfg.originRampSet;
            startOk = 1'b1;
          end else if (cmd.stepStart) begin
            s_d.mode = spn_pkg::MD_STEP;
            s_d.bounded = 1'b1;
            // Absolute targets only when relative-only mode is off
            if (cmd.stepAbsolute && !s_q.opt[`SPN_OPT_REL_BIT]) begin
              delta = cmd.stepTarget - s_q.status.position; // [R16]
            end else begin
              delta = cmd.stepTarget; // [R16]
            end
            s_d.dirPos = ~delta[31];
            s_d.remain = magOf(delta);
            rampSet = cfg.stepRampSet; // [R2]
            startOk = 1'b1;
          end else if (cmd.jogRun) begin
            s_d.mode = spn_pkg::MD_JOG;
            s_d.bounded = 1'b0;
            s_d.dirPos = ~(cmd.jogReverse ^ cfg.jogDir); // [R4]
            rampSet = cfg.jogRampSet; // [R3]
            startOk = 1'b1;
          end else if (cmd.originStart) begin
            s_d.mode = spn_pkg::MD_ORIGIN;
            s_d.bounded = 1'b0;
            s_d.dirPos = ~cfg.originDir; // [R5]
            rampSet = cfg.originRampSet; // [R3]
            startOk = 1'b1;
          end else if (cmd.teachPress) begin
            s_d.mode = spn_pkg::MD_TEACH;
            s_d.bounded = 1'b1;
            s_d.dirPos = ~(cmd.teachReverse ^ cfg.jogDir); // [R4]
            s_d.remain = {17'h00000, cfg.teachAmount}; // [R7]
            rampSet = cfg.jogRampSet;
            startOk = 1'b1;
          end
          if (startOk && !rampSet) begin
            s_d.status.errActive = 1'b1; // [R2] [R3]
            s_d.status.errCode = `SPN_ERR_VEL_UNDEF;
          end else if (startOk) begin
            s_d.st = spn_pkg::ST_MOVE;
            s_d.done = 1'b0;
            s_d.vel = 19'h00000;
          end
        end
        spn_pkg::ST_MOVE, spn_pkg::ST_DECEL: begin
          // Fixed velocity step per ramp-time threshold: equal slopes [R20]
          if (accSum >= {1'b0, rampMs}) begin
            s_d.rampAcc = 11'(accSum - {1'b0, rampMs}); // [R1]
            if (s_q.st == spn_pkg::ST_MOVE && s_q.vel < velTarget) begin
              s_d.vel = s_q.vel + 19'h00001;
            end else if (s_q.st == spn_pkg::ST_DECEL) begin
              // Bounded moves creep at a floor speed to land exactly
              if (!s_q.bounded || s_q.vel > `SPN_VEL_MIN) begin
                s_d.vel = (s_q.vel == 19'h00000) ? 19'h00000 : s_q.vel - 19'h00001;
              end
            end
          end else begin
            s_d.rampAcc = accSum[10:0];
          end

          if (phaseSum >= {1'b0, `SPN_CLK_HZ}) begin
            s_d.phase = 27'(phaseSum - {1'b0, `SPN_CLK_HZ});
            emit = ~blocked && (!s_q.bounded || s_q.remain != 32'h00000000); // [R18]
          end else begin
            s_d.phase = phaseSum[26:0];
          end

          if (emit) begin
            posNext = s_q.dirPos ? s_q.status.position + 32'sh00000001
                                 : s_q.status.position - 32'sh00000001; // [R6]
            if (!s_q.opt[`SPN_OPT_REL_BIT] &&
                (posNext > `SPN_POS_MAX || posNext < `SPN_POS_MIN)) begin
              s_d.status.errActive = 1'b1; // [R16]
              s_d.status.errCode = `SPN_ERR_OVERFLOW;
              s_d.st = spn_pkg::ST_IDLE;
              s_d.vel = 19'h00000;
            end else begin
              s_d.pulse = 1'b1;
              s_d.status.position = posNext;
              if (s_q.bounded) begin
                s_d.remain = s_q.remain - 32'h00000001;
              end
              if (s_q.st == spn_pkg::ST_MOVE && s_q.vel < velTarget) begin
                s_d.accelCnt = s_q.accelCnt + 32'h00000001;
              end
            end
          end

          if (s_q.st == spn_pkg::ST_MOVE) begin
            // Symmetric ramp: brake once remaining is no more than pulses spent rising
            if ((s_q.bounded && s_q.remain <= s_q.accelCnt) ||
                (s_q.mode == spn_pkg::MD_JOG && !cmd.jogRun) ||
                (s_q.mode == spn_pkg::MD_ORIGIN && !s_q.bounded && cmd.homeSensor)) begin
              s_d.st = spn_pkg::ST_DECEL; // [R20]
            end
          end else if ((s_q.bounded && s_q.remain == 32'h00000000) ||
                       (!s_q.bounded && s_q.vel == 19'h00000)) begin
            s_d.st = spn_pkg::ST_IDLE;
            s_d.vel = 19'h00000;
            s_d.done = 1'b1;
            if (s_q.mode == spn_pkg::MD_ORIGIN && !s_q.bounded) begin
              s_d.status.position = 32'sh00000000;
              s_d.offsetPending = s_q.opt[`SPN_OPT_OFFSET_BIT]; // [R13] [R19]
              s_d.done = ~s_q.opt[`SPN_OPT_OFFSET_BIT];
            end
          end
        end
        default: begin
          s_d.st = spn_pkg::ST_IDLE;
        end
      endcase
    end

    s_d.dirPin = s_d.dirPos ^ cfg.pulseDir; // [R6]
    s_d.shared = s_q.opt[`SPN_OPT_SHARED_BIT] ? s_d.done
                                              : (s_d.st == spn_pkg::ST_DECEL); // [R12]
    s_d.status.busy = (s_d.st != spn_pkg::ST_IDLE) || s_d.offsetPending;
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
      s_q.st <= spn_pkg::ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign pulseOut = s_q.pulse;
  assign dirOut = s_q.dirPin;
  assign sharedOut = s_q.shared;
  assign status = s_q.status;

endmodule : spn_nc_core

/* File: verilog/spn_map.svh */
/*
  Constants for the positioning NC settings block: timing, input bit
  positions, option bit positions and error codes.
  Assumes inclusion by the core module only; the package does not include it.
*/
`ifndef SPN_MAP_SVH
`define SPN_MAP_SVH

// Clock and ramp reference
`define SPN_CLK_HZ 27'h5F5E100
`define SPN_CLK_PERIOD_NS 10
`define SPN_REF_PPS 19'h7A120
`define SPN_RAMP_MS_MIN 11'h00A
`define SPN_RAMP_MS_MAX 11'h7D0
// Velocity steps per clock: reference velocity times clock period over 1 ms
`define SPN_RAMP_INC (3'((500000 * `SPN_CLK_PERIOD_NS) / 1000000))
`define SPN_RAMP_INC_S 3'h2
`define SPN_S_BAND_PPS 19'h061A8
`define SPN_S_LINEAR_HI 4'hA
`define SPN_VEL_MIN 19'h003E8

// Input polarity mask bit positions
`define SPN_IN_CW_BIT 0
`define SPN_IN_CCW_BIT 1
`define SPN_IN_EMG_BIT 5

// Option bit positions
`define SPN_OPT_SHARED_BIT 0
`define SPN_OPT_OFFSET_BIT 1
`define SPN_OPT_EMG_RST_BIT 3
`define SPN_OPT_REL_BIT 4
`define SPN_OPT_SVOFF_BIT 5
`define SPN_OPT_LIMTQ_BIT 6

// Error codes
`define SPN_ERR_NONE 8'h00
`define SPN_ERR_VEL_UNDEF 8'h34
`define SPN_ERR_EMG 8'h35
`define SPN_ERR_OVERFLOW 8'h3A

// Coordinate range
`define SPN_POS_MAX 32'sh3FFFFFFF
`define SPN_POS_MIN 32'shC0000000

`endif

/* File: verilog/spn_pkg.sv */
/*
  Types for the positioning NC settings block: states, modes and the
  configuration, command, status and state carriers.
  Assumes nothing from spn_map.svh, which only the core includes.
*/
package spn_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_MOVE = 3'h2,
    ST_DECEL = 3'h4
  } spn_state_e;

  typedef enum logic [1:0] {
    MD_STEP = 2'h0,
    MD_JOG = 2'h1,
    MD_ORIGIN = 2'h2,
    MD_TEACH = 2'h3
  } spn_mode_e;

  typedef struct packed {
    logic [10:0] stepRampMs;
    logic [10:0] jogRampMs;
    logic [10:0] originRampMs;
    logic stepRampSet;
    logic jogRampSet;
    logic originRampSet;
    logic jogDir;
    logic originDir;
    logic pulseDir;
    logic [14:0] teachAmount;
    logic [3:0] sCurve;
    logic [12:0] inputMask;
    logic [6:0] optionWord;
    logic signed [31:0] originOffset;
  } spn_cfg_s;

  typedef struct packed {
    logic stepStart;
    logic stepAbsolute;
    logic signed [31:0] stepTarget;
    logic jogRun;
    logic jogReverse;
    logic originStart;
    logic teachPress;
    logic teachReverse;
    logic resetCmd;
    logic servoOn;
    logic homeSensor;
    logic [18:0] velPps;
    logic [12:0] rawInputs;
  } spn_cmd_s;

  typedef struct packed {
    logic [7:0] errCode;
    logic errActive;
    logic busy;
    logic signed [31:0] position;
    logic torqueInhibitCw;
    logic torqueInhibitCcw;
  } spn_status_s;

  typedef struct packed {
    spn_state_e st;
    spn_mode_e mode;
    logic [18:0] vel;
    logic [10:0] rampAcc;
    logic [26:0] phase;
    logic [31:0] remain;
    logic [31:0] accelCnt;
    logic bounded;
    logic dirPos;
    logic offsetPending;
    logic emgLatched;
    logic [6:0] opt;
    logic optTaken;
    logic pulse;
    logic dirPin;
    logic shared;
    logic done;
    spn_status_s status;
  } spn_state_s;

endpackage : spn_pkg

/* File: verif/spn_motor_model.sv */
/*
  Motor and home sensor model, stepped by the core's pulse and direction.
  Assumes pulse and direction registered on mclk.
*/
module spn_motor_model #(
  parameter int HomePos = 5
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic pulseOut,
  input wire logic dirOut,
  output logic homeSensor
);
  timeunit 1ns;
  timeprecision 1ps;
  int pos_q;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pos_q <= 0;
    end else if (pulseOut) begin
      pos_q <= dirOut ? pos_q + 1 : pos_q - 1;
    end
  end
  // One pulse wide: a lost pulse misses the origin
  assign homeSensor = (pos_q == HomePos);
endmodule : spn_motor_model

/* File: verif/spn_nc_core_properties.sv */
/*
  Checker for the positioning NC core, seeing only its ports.
  Assumes one clock domain; keeps its own copy of the latched option word.
*/
module spn_nc_core_checker (
  input wire logic mclk,
  input wire logic resetn,
  input wire spn_pkg::spn_cfg_s cfg,
  input wire spn_pkg::spn_cmd_s cmd,
  input wire logic pulseOut,
  input wire logic dirOut,
  input wire logic sharedOut,
  input wire spn_pkg::spn_status_s status
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] optWord_q;
  logic optLive_q;
  logic emergency_stop_input;
  logic [1:0] lim;
  assign emergency_stop_input = cmd.rawInputs[5] ^ cfg.inputMask[5];
  assign lim = cmd.rawInputs[1:0] ^ cfg.inputMask[1:0];
  // Live port may change later; only the first value counts
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      optWord_q <= 7'h00;
      optLive_q <= 1'b0;
    end else if (!optLive_q) begin
      optWord_q <= cfg.optionWord;
      optLive_q <= 1'b1;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////
  sequence errSeq(logic [7:0] code);
    status.errActive && status.errCode == code;
  endsequence
  sequence idleSeq;
    optLive_q && !status.busy && !status.errActive && cmd.servoOn && !emergency_stop_input;
  endsequence
  unset_step_a: assert property (idleSeq ##0 (cmd.stepStart && !cfg.stepRampSet)
    |=> errSeq(8'h34)) else $error("step with unset ramp not refused");
  unset_jog_a: assert property (idleSeq ##0 (!cmd.stepStart && cmd.jogRun &&
    !cfg.jogRampSet) |=> errSeq(8'h34)) else $error("jog with unset ramp not refused");
  emg_raise_a: assert property (optLive_q && emergency_stop_input && !status.errActive
    |=> errSeq(8'h35)) else $error("emergency not flagged");
  emg_hold_a: assert property (errSeq(8'h35) ##0 !optWord_q[3]
    |=> status.errActive) else $error("emergency error left early");
  emg_clear_a: assert property (errSeq(8'h35) ##0 (optWord_q[3] && cmd.resetCmd && !emergency_stop_input)
    |=> !status.errActive) else $error("reset command did not recover");
  err_stand_a: assert property (status.errActive && !cmd.resetCmd
    |=> status.errActive) else $error("error dropped without reset");
  err_refuse_a: assert property (status.errActive && !status.busy
    |=> !status.busy) else $error("move started under error");
  torque_mask_a: assert property (optLive_q |=> {status.torqueInhibitCcw,
    status.torqueInhibitCw} == $past(lim & {2{!optWord_q[6]}})) else $error("torque inhibit");
  shared_decel_a: assert property (optLive_q && !optWord_q[0] && sharedOut
    |-> status.busy) else $error("decel output while stopped");
  pulse_width_a: assert property (pulseOut |=> !pulseOut) else $error("pulse too wide");
endmodule : spn_nc_core_checker

/* File: verif/spn_nc_core_test.sv */
/*
  Self-checking bench for the positioning NC core, one task per scenario.
  Assumes the motor model and checker are compiled before it.
*/
module spn_nc_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic pulseOut;
  logic dirOut;
  logic sharedOut;
  logic homeSensor;
  spn_pkg::spn_cfg_s cfg;
  spn_pkg::spn_cmd_s cmdDrv;
  spn_pkg::spn_cmd_s cmd;
  spn_pkg::spn_status_s status;
  int err_count = 0;
  int n_checks = 0;
  always #5 mclk = ~mclk;
  always_comb begin
    cmd = cmdDrv;
    cmd.homeSensor = homeSensor;
  end
  spn_nc_core dut (.mclk(mclk), .resetn(resetn), .cfg(cfg), .cmd(cmd), .pulseOut(pulseOut),
    .dirOut(dirOut), .sharedOut(sharedOut), .status(status));
  spn_motor_model motor (.mclk(mclk), .resetn(resetn), .pulseOut(pulseOut), .dirOut(dirOut),
    .homeSensor(homeSensor));
  ////////////////////////////////////////////////////////////
  task conclude;
    if (err_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  task chk(input bit ok, input string m);
    n_checks++;
    if (!ok) begin
      err_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick
  // Options only take at power reset, so each setting needs one
  task pwr(input logic [6:0] opt);
    resetn <= 1'b0;
    cfg.optionWord <= opt & 7'h7B;
    tick(4);
    resetn <= 1'b1;
    tick(3);
    #1;
  endtask : pwr
  task fire(input int k);
    tick(1);
    case (k)
      0: cmdDrv.stepStart <= 1'b1;
      1: cmdDrv.jogRun <= 1'b1;
      2: cmdDrv.originStart <= 1'b1;
      4: cmdDrv.teachPress <= 1'b1;
      default: cmdDrv.resetCmd <= 1'b1;
    endcase
    tick(1);
    cmdDrv.teachPress <= 1'b0;
    cmdDrv.stepStart <= 1'b0;
    cmdDrv.originStart <= 1'b0;
    cmdDrv.resetCmd <= 1'b0;
    #1;
  endtask : fire
  task waitBusy(input logic v, input int lim);
    for (int i = 0; i < lim && status.busy !== v; i++) @(posedge mclk);
    #1;
    if (status.busy !== v) begin
      err_count++;
      $display("[FAIL] %0t busy wait expired", $time);
      conclude();
    end
  endtask : waitBusy
  ////////////////////////////////////////////////////////////
  task testUnset;
    for (int k = 0; k < 3; k++) begin
      {cfg.stepRampSet, cfg.jogRampSet, cfg.originRampSet} <= ~(3'h4 >> k);
      pwr(7'h00);
      fire(k);
      chk(status.errActive === 1'b1 && status.errCode === 8'h34, "unset ramp");
      cmdDrv.jogRun <= 1'b0;
      fire(3);
      chk(status.errActive === 1'b0, "reset command left error");
      {cfg.stepRampSet, cfg.jogRampSet, cfg.originRampSet} <= 3'h7;
      fire(k);
      chk(status.busy === 1'b1, "move with set ramp refused");
      cmdDrv.servoOn <= 1'b0;
      cmdDrv.jogRun <= 1'b0;
      waitBusy(1'b0, 4);
      chk(status.busy === 1'b0, "servo off did not abort");
      cmdDrv.servoOn <= 1'b1;
    end
  endtask : testUnset
  task testEmg;
    pwr(7'h00);
    cmdDrv.rawInputs[5] <= 1'b1;
    tick(1);
    #1;
    chk(status.errActive === 1'b1 && status.errCode === 8'h35, "emergency");
    cmdDrv.rawInputs[5] <= 1'b0;
    cfg.optionWord <= 7'h08;
    fire(3);
    chk(status.errActive === 1'b1, "cleared without power reset");
    cfg.inputMask <= 13'h0020;
    pwr(7'h09);
    chk(status.errCode === 8'h35, "inverted emergency unseen");
    cfg.inputMask <= 13'h0000;
    fire(3);
    chk(status.errActive === 1'b0, "reset command did not recover");
  endtask : testEmg
  task testLimit;
    logic [1:0] tq;
    for (int b = 0; b < 2; b++) begin
      cfg.inputMask <= 13'h0023;
      cmdDrv.rawInputs <= 13'h0020;
      pwr({b[0], 6'h00});
      tq = {status.torqueInhibitCw, status.torqueInhibitCcw};
      chk(tq === {2{!b[0]}}, "limit torque wrong");
    end
    cfg.inputMask <= 13'h0000;
    cmdDrv.rawInputs <= 13'h0000;
  endtask : testLimit
  task testShared;
    bit saw;
    saw = 1'b0;
    pwr(7'h20);
    fire(1);
    chk(status.busy === 1'b1, "jog did not start");
    cmdDrv.servoOn <= 1'b0;
    tick(3);
    #1;
    chk(status.busy === 1'b1, "servo off dropped held move");
    cmdDrv.servoOn <= 1'b1;
    cmdDrv.jogRun <= 1'b0;
    for (int i = 0; i < 50000 && status.busy === 1'b1; i++) begin
      saw |= (sharedOut === 1'b1);
      tick(1);
      #1;
    end
    chk(saw && status.busy === 1'b0, "no decel indication");
    pwr(7'h01);
    fire(1);
    cmdDrv.jogRun <= 1'b0;
    waitBusy(1'b0, 50000);
    chk(sharedOut === 1'b1, "no finished indication");
  endtask : testShared
  // A pulse costs thousands of ramp cycles, so teachAmount is set to one pulse per press
  task testTeach;
    int np;
    logic dirSeen;
    cmdDrv.velPps <= 19'h7A120;
    cmdDrv.stepTarget <= 32'sh00000001;
    cfg.teachAmount <= 15'h0001;
    cfg.pulseDir <= 1'b1;
    pwr(7'h00);
    for (int j = 0; j < 2; j++) begin
      np = 0;
      dirSeen = 1'b0;
      cfg.jogDir <= j[0];
      fire(4);
      for (int i = 0; i < 30000 && status.busy === 1'b1; i++) begin
        if (pulseOut === 1'b1) begin
          np++;
          dirSeen = dirOut;
        end
        tick(1);
        #1;
      end
      chk(np == 1 && status.busy === 1'b0, "teach pulse count");
      chk(status.position === 32'(1 - j) && dirSeen === j[0], "teach direction");
      if (j == 0) begin
        // Absolute target equal to position: zero-length move
        fire(0);
        waitBusy(1'b0, 5);
        chk(status.position === 32'sh00000001, "absolute step moved");
      end
    end
  endtask : testTeach
  initial begin
    cfg = '0;
    cfg.stepRampMs = 11'h00A;
    cfg.jogRampMs = 11'h00A;
    cfg.originRampMs = 11'h00A;
    cmdDrv = '0;
    cmdDrv.servoOn = 1'b1;
    cmdDrv.stepAbsolute = 1'b1;
    cmdDrv.stepTarget = 32'sh000003E8;
    cmdDrv.velPps = 19'h003E8;
    testUnset();
    testEmg();
    testLimit();
    testShared();
    testTeach();
    conclude();
  end
endmodule : spn_nc_core_test

bind spn_nc_core spn_nc_core_checker props (.mclk(mclk), .resetn(resetn), .cfg(cfg),
  .cmd(cmd), .pulseOut(pulseOut), .dirOut(dirOut), .sharedOut(sharedOut), .status(status));
